// ==== alu_regs.svh ====
`ifndef ALU_REGS_SVH
`define ALU_REGS_SVH

// ----------------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------------
`define FLAG_C_POS        3'd0
`define FLAG_Z_POS        3'd1
`define FLAG_N_POS        3'd2
`define FLAG_V_POS        3'd3
`define FLAG_S_POS        3'd4
`define FLAG_H_POS        3'd5
`define FLAG_T_POS        3'd6
`define FLAG_I_POS        3'd7

// ----------------------------------------------------------------------
// Reset values and register-port offsets
// ----------------------------------------------------------------------
`define STATUS_RESET      8'h00
`define PC_RESET          16'h0000
`define REG_STATUS_OFS    8'h00
`define REG_PC_OFS        8'h01
`define REG_LAST_OFS      8'h02

// ----------------------------------------------------------------------
// Opcode patterns and cycle counts
// ----------------------------------------------------------------------
`define OPC_NOP           16'h0000
`define OPC_SLEEP         16'h9588
`define OPC_KICK          16'h95a8
`define WORD_ADD_CYCLES   2'd2
`define BRANCH_CYCLES     2'd2

`endif

// ==== alu_pkg.sv ====
package alu_pkg;

    typedef enum logic [4:0] {
        OP_NONE  = 5'b0_0001,
        OP_ADD8  = 5'b0_0010,
        OP_LOGIC = 5'b0_0100,
        OP_WORD  = 5'b0_1000,
        OP_OTHER = 5'b1_0000
    } op_class_type;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_WAIT = 2'b10
    } exec_state_type;

    typedef struct packed {
        logic [7:0] result;
        logic       half;
        logic       carry;
        logic       over;
    } add_res_type;

endpackage : alu_pkg

// ==== alu_add_if.sv ====
`timescale 1ns/1ps
interface alu_add_if;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    alu_pkg::add_res_type res;
    modport core  (output a, output b, output cin, input res);
    modport adder (input a, input b, input cin, output res);
endinterface : alu_add_if

// ==== alu_adder8.sv ====
`timescale 1ns/1ps
module alu_adder8
    import alu_pkg::*;
(
    alu_add_if.adder port_if
);
    logic [8:0] sum;
    logic [4:0] low;

    // -------------------------------------------------------------------
    // Eight-bit add with carry, half-carry and overflow outputs
    // -------------------------------------------------------------------
    always_comb begin
        sum = {1'b0, port_if.a} + {1'b0, port_if.b} + {8'h00, port_if.cin};
        low = {1'b0, port_if.a[3:0]} + {1'b0, port_if.b[3:0]}
              + {4'h0, port_if.cin};
        port_if.res.result = sum[7:0];
        port_if.res.half   = low[4]; // RULE_03
        port_if.res.carry  = sum[8]; // RULE_06
        port_if.res.over   = (port_if.a[7] == port_if.b[7])
                             && (sum[7] != port_if.a[7]); // RULE_04
    end
endmodule : alu_adder8

// ==== alu_flag_unit.sv ====
// Functional notes
// RULE_01: Add-with-carry writes Rd plus Rr plus carry into Rd.
// RULE_02: Plain add writes Rd plus Rr into Rd, carry ignored.
// RULE_03: Half-carry set on carry out of bit 3 for 8-bit adds.
// RULE_04: Overflow set when operands share sign and result sign differs.
// RULE_05: N is bit 7, Z when result zero, S is N xor V.
// RULE_06: Carry set on carry out of bit 7 for 8-bit adds.
// RULE_07: Word add adds 0..63 to pair 24/26/28/30, two cycles.
// RULE_08: Word add Z on 16-bit zero, V and C from bit 15 rules.
// RULE_09: Register AND stores Rd and Rr, clears V, keeps H and C.
// RULE_10: Immediate AND on r16..r31 with split 8-bit constant.
// RULE_11: Arithmetic shift right keeps bit 7, carry gets old bit 0.
// RULE_12: After shift, V equals N xor C.
// RULE_13: Flag clear zeroes exactly the selected flag bit.
// RULE_14: Flag bits: I7 T6 H5 S4 V3 N2 Z1 C0.
// RULE_15: Bit load copies T into selected destination bit only.
// RULE_16: Branch on cleared flag jumps to PC plus offset plus one.
// RULE_17: Branch offset is 7-bit signed, sign extended.
// RULE_18: Branch takes one cycle if not taken, two if taken.
// RULE_19: Other operations advance PC by one in one cycle.
// RULE_20: No-op, sleep and watchdog kick change nothing here.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "alu_regs.svh"
module alu_flag_unit
    import alu_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // Instruction issue
    input  wire logic        instr_valid_in,
    input  wire logic [15:0] instr_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    // Core state
    output logic      [7:0]  status_flags_out,
    output logic      [15:0] pc_out,
    output logic             busy_out,
    output logic             retire_out,
    output logic             sleep_req_out,
    output logic             watchdog_kick_op_out
);

    typedef struct packed {
        exec_state_type state;
        logic [7:0]     flags;
        logic [15:0]    pc;
        logic [15:0]    pend_pc;
        logic [4:0]     pend_idx;
        logic [15:0]    pend_word;
        logic           pend_wr;
        logic [7:0]     rdata;
        logic           retire;
        logic           sleep;
        logic           kick;
    } state_type;

    state_type   cur_r;
    state_type   cur_nxt;
    logic [7:0]  gpr_r [0:31];
    logic        wr_en;
    logic [4:0]  wr_idx;
    logic [7:0]  wr_val;
    logic        wr2_en;
    logic [7:0]  wr2_val;

    alu_add_if add_if ();

    alu_adder8 u_adder (
        .port_if (add_if.adder)
    );

    // -------------------------------------------------------------------
    // Opcode fields
    // -------------------------------------------------------------------
    logic [4:0]  rd_idx;
    logic [4:0]  rr_idx;
    logic [4:0]  hi_idx;
    logic [4:0]  pair_idx;
    logic [7:0]  imm8;
    logic [5:0]  imm6;
    logic [2:0]  sel3;
    logic [15:0] offs;
    logic [7:0]  rd_val;
    logic [7:0]  rr_val;
    logic [15:0] pair_val;
    logic [15:0] word_sum;

    always_comb begin
        rd_idx   = instr_in[8:4];
        rr_idx   = {instr_in[9], instr_in[3:0]};
        hi_idx   = {1'b1, instr_in[7:4]}; // RULE_10
        pair_idx = {2'b11, instr_in[5:4], 1'b0}; // RULE_07
        imm8     = {instr_in[11:8], instr_in[3:0]}; // RULE_10
        imm6     = {instr_in[7:6], instr_in[3:0]};
        sel3     = instr_in[2:0];
        offs     = {{9{instr_in[9]}}, instr_in[9:3]}; // RULE_17
        rd_val   = gpr_r[rd_idx];
        rr_val   = gpr_r[rr_idx];
        pair_val = {gpr_r[pair_idx + 5'd1], gpr_r[pair_idx]};
        word_sum = pair_val + {10'h000, imm6};
    end

    assign add_if.a   = rd_val;
    assign add_if.b   = rr_val;
    assign add_if.cin = (instr_in[15:10] == 6'b0001_11)
                        ? cur_r.flags[`FLAG_C_POS] : 1'b0; // RULE_01 RULE_02

    // -------------------------------------------------------------------
    // Opcode classes
    // -------------------------------------------------------------------
    logic        is_add;
    logic        is_and;
    logic        is_andi;
    logic        is_asr;
    logic        is_wadd;
    logic        is_bclr;
    logic        is_bld;
    logic        is_brbc;
    logic        is_sleep;
    logic        is_kick;

    // Each class is decoded on its full fixed field, so neighbouring
    // opcodes outside this block fall through as plain no-operations.
    always_comb begin
        is_add   = (instr_in[15:10] == 6'b0000_11)
                   || (instr_in[15:10] == 6'b0001_11); // RULE_01 RULE_02
        is_and   = (instr_in[15:10] == 6'b0010_00); // RULE_09
        is_andi  = (instr_in[15:12] == 4'b0111); // RULE_10
        is_asr   = (instr_in[15:9] == 7'b1001_010)
                   && (instr_in[3:0] == 4'b0101); // RULE_11
        is_wadd  = (instr_in[15:8] == 8'h96); // RULE_07
        is_bclr  = (instr_in[15:7] == 9'b1001_0100_1)
                   && (instr_in[3:0] == 4'b1000); // RULE_13
        is_bld   = (instr_in[15:9] == 7'b1111_100)
                   && (instr_in[3] == 1'b0); // RULE_15
        is_brbc  = (instr_in[15:10] == 6'b1111_01); // RULE_16
        is_sleep = (instr_in == `OPC_SLEEP); // RULE_20
        is_kick  = (instr_in == `OPC_KICK); // RULE_20
    end

    // -------------------------------------------------------------------
    // Execute
    // -------------------------------------------------------------------
    always_comb begin
        logic [7:0] res;
        logic [7:0] f;
        logic       set_nz;
        res      = 8'h00;
        f        = cur_r.flags;
        set_nz   = 1'b0;
        cur_nxt  = cur_r;
        cur_nxt.retire = 1'b0;
        cur_nxt.sleep  = 1'b0;
        cur_nxt.kick   = 1'b0;
        cur_nxt.rdata  = 8'h00;
        wr_en    = 1'b0;
        wr_idx   = rd_idx;
        wr_val   = 8'h00;
        wr2_en   = 1'b0;
        wr2_val  = 8'h00;
        case (cur_r.state)
        ST_RUN: begin
            if (instr_valid_in) begin
                cur_nxt.pc     = cur_r.pc + 16'h0001; // RULE_19
                cur_nxt.retire = 1'b1;
                if (is_add) begin
                    res   = add_if.res.result; // RULE_01 RULE_02
                    wr_en = 1'b1;
                    f[`FLAG_H_POS] = add_if.res.half; // RULE_03
                    f[`FLAG_V_POS] = add_if.res.over; // RULE_04
                    f[`FLAG_C_POS] = add_if.res.carry; // RULE_06
                    set_nz = 1'b1;
                end else if (is_and) begin
                    res   = rd_val & rr_val; // RULE_09
                    wr_en = 1'b1;
                    f[`FLAG_V_POS] = 1'b0; // RULE_09
                    set_nz = 1'b1;
                end else if (is_andi) begin
                    res    = gpr_r[hi_idx] & imm8; // RULE_10
                    wr_idx = hi_idx;
                    wr_en  = 1'b1;
                    f[`FLAG_V_POS] = 1'b0; // RULE_10
                    set_nz = 1'b1;
                end else if (is_asr) begin
                    res   = {rd_val[7], rd_val[7:1]}; // RULE_11
                    wr_en = 1'b1;
                    f[`FLAG_C_POS] = rd_val[0]; // RULE_11
                    f[`FLAG_V_POS] = res[7] ^ rd_val[0]; // RULE_12
                    set_nz = 1'b1;
                end else if (is_wadd) begin
                    cur_nxt.state     = ST_WAIT; // RULE_07
                    cur_nxt.pend_pc   = cur_r.pc + 16'h0001;
                    cur_nxt.pend_idx  = pair_idx;
                    cur_nxt.pend_word = word_sum;
                    cur_nxt.pend_wr   = 1'b1;
                    cur_nxt.pc        = cur_r.pc;
                    cur_nxt.retire    = 1'b0;
                    f[`FLAG_V_POS] = ~pair_val[15] & word_sum[15]; // RULE_08
                    f[`FLAG_C_POS] = pair_val[15] & ~word_sum[15]; // RULE_08
                    f[`FLAG_N_POS] = word_sum[15];
                    f[`FLAG_Z_POS] = (word_sum == 16'h0000); // RULE_08
                    f[`FLAG_S_POS] = f[`FLAG_N_POS] ^ f[`FLAG_V_POS];
                end else if (is_bclr) begin
                    f[instr_in[6:4]] = 1'b0; // RULE_13 RULE_14
                end else if (is_bld) begin
                    res = rd_val;
                    res[sel3] = cur_r.flags[`FLAG_T_POS]; // RULE_15
                    wr_en = 1'b1;
                end else if (is_brbc) begin
                    if (!cur_r.flags[sel3]) begin // RULE_16
                        cur_nxt.state   = ST_WAIT; // RULE_18
                        cur_nxt.pend_pc = cur_r.pc + offs + 16'h0001;
                        cur_nxt.pend_wr = 1'b0;
                        cur_nxt.pc      = cur_r.pc;
                        cur_nxt.retire  = 1'b0;
                    end
                end else if (is_sleep) begin
                    cur_nxt.sleep = 1'b1; // RULE_20
                end else if (is_kick) begin
                    cur_nxt.kick = 1'b1; // RULE_20
                end
                if (set_nz) begin
                    f[`FLAG_N_POS] = res[7]; // RULE_05
                    f[`FLAG_Z_POS] = (res == 8'h00); // RULE_05
                    f[`FLAG_S_POS] = res[7] ^ f[`FLAG_V_POS]; // RULE_05
                end
                wr_val = res;
                cur_nxt.flags = f;
            end
        end
        ST_WAIT: begin
            cur_nxt.state  = ST_RUN; // RULE_07 RULE_18
            cur_nxt.pc     = cur_r.pend_pc;
            cur_nxt.retire = 1'b1;
            cur_nxt.pend_wr = 1'b0;
            if (cur_r.pend_wr) begin
                wr_en   = 1'b1;
                wr_idx  = cur_r.pend_idx;
                wr_val  = cur_r.pend_word[7:0];
                wr2_en  = 1'b1;
                wr2_val = cur_r.pend_word[15:8];
            end
        end
        default: begin
            cur_nxt.state = ST_RUN;
        end
        endcase
        // Software status writes land after execution so they take priority.
        if (reg_wr_in && reg_addr_in == `REG_STATUS_OFS) begin
            cur_nxt.flags = reg_wdata_in;
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
            `REG_STATUS_OFS: cur_nxt.rdata = cur_r.flags;
            `REG_PC_OFS:     cur_nxt.rdata = cur_r.pc[7:0];
            `REG_LAST_OFS:   cur_nxt.rdata = cur_r.pc[15:8];
            default:         cur_nxt.rdata = 8'h00;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // State registers
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur_r           <= '0;
            cur_r.state     <= ST_RUN;
            cur_r.flags     <= `STATUS_RESET;
            cur_r.pc        <= `PC_RESET;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Register file
    // -------------------------------------------------------------------
    // The register file has no reset, which keeps it a plain memory;
    // its contents are unknown until instructions load them.
    always_ff @(posedge core_clk_in) begin
        if (wr_en) begin
            gpr_r[wr_idx] <= wr_val;
        end
        if (wr2_en) begin
            gpr_r[wr_idx + 5'd1] <= wr2_val;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    // Busy is the wait bit of the one-hot state, so no gate sits behind it.
    always_comb begin
        reg_rdata_out        = cur_r.rdata;
        status_flags_out     = cur_r.flags;
        pc_out               = cur_r.pc;
        busy_out             = cur_r.state[1];
        retire_out           = cur_r.retire;
        sleep_req_out        = cur_r.sleep;
        watchdog_kick_op_out = cur_r.kick;
    end

endmodule : alu_flag_unit

// ==== alu_flag_sva.sv ====
`timescale 1ns/1ps
`include "alu_regs.svh"
module alu_flag_sva
    import alu_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    // Issue and state
    input wire logic        instr_valid_in,
    input wire logic [15:0] instr_in,
    input wire logic        busy_out,
    input wire logic        retire_out,
    input wire logic [7:0]  status_flags_out,
    input wire logic [15:0] pc_out
);
    // ---
    // Issue decode
    // ---
    logic tk, br, wd;
    logic [7:0] f_s;
    assign tk  = instr_valid_in && !busy_out;
    assign br  = tk && (instr_in ==? 16'b1111_01??_????_????);
    assign wd  = tk && (instr_in[15:8] == 8'h96);
    assign f_s = status_flags_out;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_two;
        busy_out && !retire_out ##1 retire_out && !busy_out;
    endsequence
    property p_wpc;
        logic [15:0] p;
        (wd, p = pc_out) |=> $stable(pc_out) ##1 pc_out == p + 16'h0001;
    endproperty
    property p_brt;
        logic [15:0] p;
        (br && !f_s[instr_in[2:0]],
         p = pc_out + {{9{instr_in[9]}}, instr_in[9:3]} + 16'h0001)
        |=> s_two ##0 pc_out == p;
    endproperty
    property p_brn;
        logic [15:0] p;
        (br && f_s[instr_in[2:0]], p = pc_out)
        |=> retire_out && !busy_out && pc_out == p + 16'h0001;
    endproperty
    property p_bclr;
        logic [7:0] f;
        (tk && (instr_in ==? 16'b1001_0100_1???_1000),
         f = f_s & ~(8'h01 << instr_in[6:4])) |=> f_s == f;
    endproperty
    property p_and;
        logic [7:0] f;
        (tk && (instr_in ==? 16'b0?1?_????_????_????)
            && (instr_in[15:10] == 6'h08 || instr_in[15:12] == 4'h7),
         f = f_s) |=> (f_s & 8'h29) == (f & 8'h21);
    endproperty
    AST_WORD_TWO: assert property (wd |=> s_two)
        else $error("word add did not take two cycles");
    AST_WORD_PC: assert property (p_wpc)
        else $error("word add program counter step wrong");
    AST_BR_TAKEN: assert property (p_brt)
        else $error("taken branch target or timing wrong");
    AST_BR_NOT: assert property (p_brn)
        else $error("untaken branch target or timing wrong");
    AST_CLEAR: assert property (p_bclr)
        else $error("flag clear touched the wrong bits");
    AST_AND_FLAGS: assert property (p_and)
        else $error("logic and flag handling wrong");
    AST_ADD_ONE: assert property (tk
        && (instr_in ==? 16'b000?_11??_????_????)
        |=> retire_out && f_s[4] == (f_s[2] ^ f_s[3]))
        else $error("add not retired in one cycle with sign flag");
    AST_SHIFT_V: assert property (tk
        && (instr_in ==? 16'b1001_010?_????_0101)
        |=> f_s[3] == (f_s[2] ^ f_s[0]))
        else $error("shift overflow flag wrong");
    AST_QUIET: assert property (tk && ((instr_in ==? 16'b1111_100?_????_0???)
        || instr_in == `OPC_NOP || instr_in == `OPC_SLEEP
        || instr_in == `OPC_KICK) |=> retire_out && $stable(f_s))
        else $error("quiet operation changed flags");
endmodule : alu_flag_sva

bind alu_flag_unit alu_flag_sva u_alu_flag_sva (
    .core_clk_in(core_clk_in), .rst_in(rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .busy_out(busy_out), .retire_out(retire_out),
    .status_flags_out(status_flags_out), .pc_out(pc_out));

// ==== instr_source.sv ====
`timescale 1ns/1ps
// ---
// Decoder side model
// ---
// Idle opcode lines show the inverse of the last opcode, so a design
// that samples them without valid cannot get a lucky match.
module instr_source (
    // Request from bench
    input  wire logic        go_in,
    input  wire logic [15:0] op_in,
    // Issue port
    output logic             instr_valid_out,
    output logic [15:0]      instr_out
);
    assign instr_valid_out = go_in;
    assign instr_out       = go_in ? op_in : ~op_in;
endmodule : instr_source

// ==== tb.sv ====
`timescale 1ns/1ps
`include "alu_regs.svh"
module tb;
    // ---
    // Bench state
    // ---
    logic core_clk_in, rst_in, go, instr_valid_in, reg_wr_in, reg_rd_in;
    logic busy_out, retire_out, sleep_req_out, watchdog_kick_op_out;
    logic [15:0] op, instr_in, pc_out, sd, pcm;
    logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [7:0]  status_flags_out, fl;
    logic [7:0]  rg [32];
    logic [15:0] kb [12] = '{16'h0c00, 16'h1c00, 16'h2000, 16'h7000,
        16'h9405, 16'h9488, 16'hf800, 16'hf400, 16'h9600, 16'h0000,
        16'h9588, 16'h95a8};
    logic [15:0] km [12] = '{16'h03ff, 16'h03ff, 16'h03ff, 16'h0fff,
        16'h01f0, 16'h0070, 16'h01f7, 16'h03ff, 16'h00ff, 0, 0, 0};
    int failures, total_checks, cyc;
    alu_flag_unit u_alu_flag_unit (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .status_flags_out(status_flags_out), .pc_out(pc_out),
        .busy_out(busy_out), .retire_out(retire_out),
        .sleep_req_out(sleep_req_out),
        .watchdog_kick_op_out(watchdog_kick_op_out));
    instr_source u_instr_source (.go_in(go), .op_in(op),
        .instr_valid_out(instr_valid_in), .instr_out(instr_in));
    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lf
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        @(posedge core_clk_in);
        if (a == 8'h00) fl = d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_rd_in <= 1'b1; reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk("rdata", 16'(e), 16'(reg_rdata_out));
        @(posedge core_clk_in);
    endtask : rd
    // The model runs first, then the opcode is issued and timed.
    task automatic ex(input logic [15:0] o);
        logic [7:0] a, b, r; logic [4:0] d; logic [8:0] s;
        logic [15:0] w; int n, c, nz;
        d = o[8:4]; a = rg[d]; b = rg[{o[9], o[3:0]}]; r = a;
        c = 1; n = 0; nz = 1;
        casez (o)
            16'b000?_11??_????_????: begin
                s = a + b + 9'(o[12] & fl[0]); r = s[7:0];
                fl[5] = 5'(a[3:0]) + 5'(b[3:0]) + 5'(o[12] & fl[0]) > 15;
                fl[3] = a[7] == b[7] && r[7] != a[7]; fl[0] = s[8];
            end
            16'b0010_00??_????_????: begin r = a & b; fl[3] = 0; end
            16'b0111_????_????_????: begin
                d = {1'b1, o[7:4]}; r = rg[d] & {o[11:8], o[3:0]}; fl[3] = 0;
            end
            16'b1001_010?_????_0101: begin
                r = {a[7], a[7:1]}; fl[0] = a[0]; fl[3] = a[7] ^ a[0];
            end
            16'b1001_0100_1???_1000: begin fl[o[6:4]] = 0; nz = 0; end
            16'b1111_100?_????_0???: begin r[o[2:0]] = fl[6]; nz = 0; end
            16'b1111_01??_????_????: begin
                nz = 0;
                if (!fl[o[2:0]]) begin
                    c = 2; pcm = pcm + {{9{o[9]}}, o[9:3]};
                end
            end
            16'b1001_0110_????_????: begin
                d = 5'd24 + {o[5:4], 1'b0}; c = 2; nz = 0;
                w = {rg[d + 1], rg[d]} + 16'({o[7:6], o[3:0]});
                fl[1] = w == 0; fl[2] = w[15];
                fl[3] = !rg[d + 1][7] && w[15]; fl[0] = rg[d + 1][7] && !w[15];
                fl[4] = fl[2] ^ fl[3]; r = w[7:0]; rg[d + 1] = w[15:8];
            end
            default: nz = 0;
        endcase
        rg[d] = r; pcm = pcm + 1;
        if (nz) begin
            fl[2] = r[7]; fl[1] = r == 0; fl[4] = fl[2] ^ fl[3];
        end
        go <= 1'b1; op <= o;
        @(posedge core_clk_in);
        if (c == 2) op <= 16'h7000;
        else go <= 1'b0;
        #1;
        while (retire_out !== 1'b1 && n < 4) begin
            @(posedge core_clk_in);
            go <= 1'b0;
            #1 n++;
        end
        chk("cycles", 16'(c), 16'(n + 1));
        chk("pc", pcm, pc_out);
        chk("flags", 16'(fl), 16'(status_flags_out));
        chk("sleep", 16'(o == `OPC_SLEEP), 16'(sleep_req_out));
        chk("kick", 16'(o == `OPC_KICK), 16'(watchdog_kick_op_out));
        @(posedge core_clk_in);
    endtask : ex
    // ---
    // Clock, timeout and main sequence
    // ---
    initial begin
        core_clk_in = 0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        rst_in = 1; go = 0; op = 0; reg_wr_in = 0; reg_rd_in = 0;
        reg_addr_in = 0; reg_wdata_in = 0; sd = 16'd3043; fl = 0;
        pcm = 0; failures = 0; total_checks = 0;
        repeat (2) @(posedge core_clk_in);
        rst_in <= 0;
        for (int i = 0; i < 3; i++) rd(8'(i), 8'h00);
        // Registers have no reset, so each bit is loaded through T.
        for (int i = 0; i < 32; i++) begin
            sd = lf(sd);
            for (int j = 0; j < 8; j++) begin
                wr(8'h00, {sd[15], sd[j], sd[13:8]});
                ex({7'b1111_100, 5'(i), 1'b0, 3'(j)});
            end
        end
        $display("test register load done");
        for (int i = 0; i < 400; i++) begin
            sd = lf(sd);
            if (sd[4]) wr(8'h00, sd[15:8]);
            sd = lf(sd);
            ex(kb[sd[15:12] % 12] | (lf(sd) & km[sd[15:12] % 12]));
        end
        $display("test random operations done");
        wr(8'h00, 8'h00);
        ex(16'hf600);
        ex(16'hf5f8);
        wr(8'h00, 8'hff);
        ex(16'hf600);
        wr(8'h01, 8'h55);
        wr(8'h37, 8'h5a);
        rd(8'h01, pcm[7:0]);
        rd(8'h02, pcm[15:8]);
        rd(8'h37, 8'h00);
        rd(8'h00, 8'hff);
        $display("test branch and register port done");
        tally_and_finish;
    end
endmodule : tb
